// ### hw/clk_gate_pkg.sv
`default_nettype none

package clk_gate_pkg;

  // ****************************************
  // Bus and field widths
  // ****************************************
  localparam int ADR_W   = 12;             // Byte address width of the register window
  localparam int DAT_W   = 32;             // Wishbone data width
  localparam int SEL_W   = 4;              // Byte lane selects
  localparam int PORT_N  = 5;              // Gated I/O port units A..E
  localparam int DIV_W   = 4;              // System clock divider field width
  localparam int IRQ_N   = 3;              // Interrupt status bits

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADR_W-1:0] OFS_RUN_GATE   = 12'h108;  // run_port_clock_gate
  localparam logic [ADR_W-1:0] OFS_SLEEP_GATE = 12'h118;  // sleep_port_clock_gate
  localparam logic [ADR_W-1:0] OFS_DEEP_GATE  = 12'h128;  // deep_sleep_port_clock_gate
  localparam logic [ADR_W-1:0] OFS_DS_SRC     = 12'h144;  // deep_sleep_clock_source
  localparam logic [ADR_W-1:0] OFS_FAULT_CLR  = 12'h150;  // clock_fault_clear
  localparam logic [ADR_W-1:0] OFS_LDO_RST    = 12'h160;  // regulator_reset_allow
  localparam logic [ADR_W-1:0] OFS_IRQ_STAT   = 12'h170;  // Interrupt status, write one to clear
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK   = 12'h174;  // Interrupt mask

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_INT_OSC   = 0;        // internal_osc_override
  localparam int BIT_VER_CLR   = 0;        // verification_clear_bit
  localparam int BIT_LDO_RST   = 0;        // regulator reset enable
  localparam int IRQ_CLK_FAULT = 0;        // Clock verification fault seen
  localparam int IRQ_LDO_LOSS  = 1;        // Regulator lost regulation
  localparam int IRQ_WAKE      = 2;        // Sleep or deep sleep ended

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [PORT_N-1:0] GATE_RST = 5'h00;  // Every port unclocked
  localparam logic              BIT_RST  = 1'h0;   // Single-bit controls clear
  localparam logic [IRQ_N-1:0]  IRQ_RST  = 3'h0;   // No events, all masked
  localparam logic              SRC_MAIN = 1'h0;   // Main oscillator
  localparam logic              SRC_INT  = 1'h1;   // Internal oscillator
  localparam logic [DIV_W-1:0]  DIV_RST  = 4'h0;   // Divider reset value

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } power_mode_e;

  // One Wishbone request, gathered from the bus ports
  typedef struct packed {
    logic             we;
    logic [SEL_W-1:0] sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } wb_req_s;

  // System clock source and divider
  typedef struct packed {
    logic             src;
    logic [DIV_W-1:0] div;
  } sysclk_cfg_s;

endpackage : clk_gate_pkg

`default_nettype wire

// ### hw/port_clock_gating_ctrl.sv
// Added by the designer: the Wishbone interface to the registers.
`default_nettype none

// Functional notes
// - Each gate bit enables one port clock
// - Access to unclocked port gives bus fault
// - All gate bits reset to zero
// - Run, sleep, deep gate registers, same layout
// - Sleep registers apply only with auto gating
// - Bits 0..4 gate ports A..E
// - Bits 31:5 reserved, read zero, writes ignored
// - Override: internal osc runs system in deep
// - No override: main osc stays in deep
// - Wake restores saved clock source and divider
// - Verification fault forces known good clock
// - Fault clear bit set then cleared, not self-clearing
// - Regulator loss resets part only when allowed
module port_clock_gating_ctrl (
  // Clock and reset
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_sys_rst,
  // Wishbone slave
  input  wire logic                              i_wb_cyc,
  input  wire logic                              i_wb_stb,
  input  wire logic                              i_wb_we,
  input  wire logic [clk_gate_pkg::ADR_W-1:0]    i_wb_adr,
  input  wire logic [clk_gate_pkg::SEL_W-1:0]    i_wb_sel,
  input  wire logic [clk_gate_pkg::DAT_W-1:0]    i_wb_dat,
  output logic      [clk_gate_pkg::DAT_W-1:0]    o_wb_dat,
  output logic                                   o_wb_ack,
  output logic                                   o_wb_err,
  // Power mode requests from the processor
  input  wire logic                              i_sleep_req,
  input  wire logic                              i_deep_sleep_req,
  input  wire logic                              i_wake_event,
  input  wire logic                              i_auto_sleep_gating_select,
  // Run clock configuration from the clock configuration logic
  input  wire clk_gate_pkg::sysclk_cfg_s         i_run_clk_cfg,
  // Port clock enables and access checks
  input  wire logic [clk_gate_pkg::PORT_N-1:0]   i_port_access,
  output logic      [clk_gate_pkg::PORT_N-1:0]   o_port_clk_en,
  output logic      [clk_gate_pkg::PORT_N-1:0]   o_port_bus_fault,
  // Oscillator and system clock control
  output clk_gate_pkg::sysclk_cfg_s              o_sysclk_cfg,
  output logic                                   o_int_osc_pwr_en,
  output logic                                   o_main_osc_pwr_en,
  output clk_gate_pkg::power_mode_e              o_power_mode,
  // Clock verification and regulator monitoring pins
  input  wire logic                              i_clk_verif_fault,
  output logic                                   o_good_clk_force,
  input  wire logic                              i_ldo_unregulated,
  output logic                                   o_regulator_reset,
  // Interrupt
  output logic                                   o_irq
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Word match of a byte address against a register offset
  function automatic logic reg_hit(input logic [clk_gate_pkg::ADR_W-1:0] adr,
                                   input logic [clk_gate_pkg::ADR_W-1:0] ofs);
    reg_hit = (adr[clk_gate_pkg::ADR_W-1:2] == ofs[clk_gate_pkg::ADR_W-1:2]);
  endfunction : reg_hit

  // Zero-extend an implemented field into a bus word
  function automatic logic [clk_gate_pkg::DAT_W-1:0] pad_word(input logic [clk_gate_pkg::PORT_N-1:0] v);
    pad_word = {{(clk_gate_pkg::DAT_W-clk_gate_pkg::PORT_N){1'b0}}, v};
  endfunction : pad_word

  // ****************************************
  // Declarations
  // ****************************************
  clk_gate_pkg::wb_req_s                req;               // Bundled bus request
  logic                                 req_valid;         // New request this cycle
  logic                                 wr_lane0;          // Write touching byte lane 0
  logic                                 hit_run;           // Decode strobes
  logic                                 hit_sleep;
  logic                                 hit_deep;
  logic                                 hit_ds_src;
  logic                                 hit_fclr;
  logic                                 hit_ldo;
  logic                                 hit_stat;
  logic                                 hit_mask;
  logic                                 mapped;            // Any register decoded
  logic [clk_gate_pkg::DAT_W-1:0]       rd_word;           // Read mux output

  logic [clk_gate_pkg::PORT_N-1:0]      run_gate_ff;       // Gate registers
  logic [clk_gate_pkg::PORT_N-1:0]      sleep_gate_ff;
  logic [clk_gate_pkg::PORT_N-1:0]      deep_gate_ff;
  logic                                 int_osc_ovr_ff;    // internal_osc_override
  logic                                 ver_clr_ff;        // verification_clear_bit
  logic                                 ldo_allow_ff;      // Regulator reset enable
  logic [clk_gate_pkg::IRQ_N-1:0]       irq_stat_ff;       // Sticky event bits
  logic [clk_gate_pkg::IRQ_N-1:0]       irq_mask_ff;       // Event enables
  logic [clk_gate_pkg::IRQ_N-1:0]       nxt_irq_stat;
  logic [clk_gate_pkg::IRQ_N-1:0]       irq_events;        // Event pulses

  clk_gate_pkg::power_mode_e            mode_ff;           // Current power mode
  clk_gate_pkg::power_mode_e            nxt_mode;
  logic [clk_gate_pkg::PORT_N-1:0]      nxt_port_en;       // Selected gate value
  clk_gate_pkg::sysclk_cfg_s            saved_cfg_ff;      // Clock in use at deep entry
  clk_gate_pkg::sysclk_cfg_s            nxt_sysclk_cfg;
  logic                                 deep_entry;        // Run to deep transition
  logic                                 ovr_active;        // Internal osc forced

  logic                                 fault_meta_ff;     // Fault synchroniser stage 1
  logic                                 fault_sync_ff;     // Fault synchroniser stage 2
  logic                                 fault_prev_ff;     // For edge detection
  logic                                 ldo_meta_ff;       // Regulator synchroniser stage 1
  logic                                 ldo_sync_ff;       // Regulator synchroniser stage 2
  logic                                 ldo_prev_ff;       // For edge detection

  // ****************************************
  // Bus decode
  // ****************************************
  assign req        = '{we: i_wb_we, sel: i_wb_sel, adr: i_wb_adr, dat: i_wb_dat};
  // Only one answer per request: block re-take while ack or err is out
  assign req_valid  = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
  assign hit_run    = reg_hit(req.adr, clk_gate_pkg::OFS_RUN_GATE);
  assign hit_sleep  = reg_hit(req.adr, clk_gate_pkg::OFS_SLEEP_GATE);
  assign hit_deep   = reg_hit(req.adr, clk_gate_pkg::OFS_DEEP_GATE);
  assign hit_ds_src = reg_hit(req.adr, clk_gate_pkg::OFS_DS_SRC);
  assign hit_fclr   = reg_hit(req.adr, clk_gate_pkg::OFS_FAULT_CLR);
  assign hit_ldo    = reg_hit(req.adr, clk_gate_pkg::OFS_LDO_RST);
  assign hit_stat   = reg_hit(req.adr, clk_gate_pkg::OFS_IRQ_STAT);
  assign hit_mask   = reg_hit(req.adr, clk_gate_pkg::OFS_IRQ_MASK);
  assign mapped     = hit_run | hit_sleep | hit_deep | hit_ds_src | hit_fclr | hit_ldo | hit_stat | hit_mask;
  // All implemented bits live in lane 0; other lanes hold only reserved bits
  assign wr_lane0   = req_valid & req.we & req.sel[0];

  // Read mux; reserved bits read as zero
  assign rd_word =
      hit_run    ? pad_word(run_gate_ff)                                   :
      hit_sleep  ? pad_word(sleep_gate_ff)                                 :
      hit_deep   ? pad_word(deep_gate_ff)                                  :
      hit_ds_src ? pad_word({{(clk_gate_pkg::PORT_N-1){1'b0}}, int_osc_ovr_ff}) :
      hit_fclr   ? pad_word({{(clk_gate_pkg::PORT_N-1){1'b0}}, ver_clr_ff})     :
      hit_ldo    ? pad_word({{(clk_gate_pkg::PORT_N-1){1'b0}}, ldo_allow_ff})   :
      hit_stat   ? pad_word({{(clk_gate_pkg::PORT_N-clk_gate_pkg::IRQ_N){1'b0}}, irq_stat_ff}) :
      hit_mask   ? pad_word({{(clk_gate_pkg::PORT_N-clk_gate_pkg::IRQ_N){1'b0}}, irq_mask_ff}) :
                   '0;

  // ****************************************
  // Bus answer
  // ****************************************

  // Ack or err one cycle after the request is taken; both drop the next cycle
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_err <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= req_valid & mapped;
      o_wb_err <= req_valid & ~mapped;  // Unmapped address answers with err
      o_wb_dat <= (req_valid & ~req.we) ? rd_word : '0;
    end
  end

  // ****************************************
  // Gate registers
  // ****************************************

  // Writes keep only bits 4:0; bits 31:5 are dropped
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_gate_ff   <= clk_gate_pkg::GATE_RST;
      sleep_gate_ff <= clk_gate_pkg::GATE_RST;
      deep_gate_ff  <= clk_gate_pkg::GATE_RST;
    end else begin
      if (wr_lane0 & hit_run) begin
        run_gate_ff <= req.dat[clk_gate_pkg::PORT_N-1:0];
      end
      if (wr_lane0 & hit_sleep) begin
        sleep_gate_ff <= req.dat[clk_gate_pkg::PORT_N-1:0];
      end
      if (wr_lane0 & hit_deep) begin
        deep_gate_ff <= req.dat[clk_gate_pkg::PORT_N-1:0];
      end
    end
  end

  // ****************************************
  // Single-bit control registers and interrupt mask
  // ****************************************

  // The fault clear bit is only ever changed by software
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      int_osc_ovr_ff <= clk_gate_pkg::BIT_RST;
      ver_clr_ff     <= clk_gate_pkg::BIT_RST;
      ldo_allow_ff   <= clk_gate_pkg::BIT_RST;
      irq_mask_ff    <= clk_gate_pkg::IRQ_RST;
    end else begin
      if (wr_lane0 & hit_ds_src) begin
        int_osc_ovr_ff <= req.dat[clk_gate_pkg::BIT_INT_OSC];
      end
      if (wr_lane0 & hit_fclr) begin
        ver_clr_ff <= req.dat[clk_gate_pkg::BIT_VER_CLR];
      end
      if (wr_lane0 & hit_ldo) begin
        ldo_allow_ff <= req.dat[clk_gate_pkg::BIT_LDO_RST];
      end
      if (wr_lane0 & hit_mask) begin
        irq_mask_ff <= req.dat[clk_gate_pkg::IRQ_N-1:0];
      end
    end
  end

  // ****************************************
  // Power mode state machine
  // ****************************************

  // Deep request wins over plain sleep when both arrive together
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      clk_gate_pkg::MODE_RUN: begin
        if (i_deep_sleep_req) begin
          nxt_mode = clk_gate_pkg::MODE_DEEP;
        end else if (i_sleep_req) begin
          nxt_mode = clk_gate_pkg::MODE_SLEEP;
        end
      end
      clk_gate_pkg::MODE_SLEEP: begin
        if (i_wake_event) begin
          nxt_mode = clk_gate_pkg::MODE_RUN;
        end
      end
      clk_gate_pkg::MODE_DEEP: begin
        if (i_wake_event) begin
          nxt_mode = clk_gate_pkg::MODE_RUN;
        end
      end
      default: begin
        nxt_mode = clk_gate_pkg::MODE_RUN;
      end
    endcase
  end

  assign deep_entry = (mode_ff == clk_gate_pkg::MODE_RUN) && (nxt_mode == clk_gate_pkg::MODE_DEEP);

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_ff <= clk_gate_pkg::MODE_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ****************************************
  // Gate selection
  // ****************************************

  // Choose by the mode being entered, so the new enables land with the state
  always_comb begin
    case (nxt_mode)
      clk_gate_pkg::MODE_SLEEP: begin
        nxt_port_en = i_auto_sleep_gating_select ? sleep_gate_ff : run_gate_ff;
      end
      clk_gate_pkg::MODE_DEEP: begin
        nxt_port_en = i_auto_sleep_gating_select ? deep_gate_ff : run_gate_ff;
      end
      default: begin
        nxt_port_en = run_gate_ff;
      end
    endcase
  end

  // Enables leave a flop so the downstream clock gates see no hazards
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_port_clk_en    <= clk_gate_pkg::GATE_RST;
      o_port_bus_fault <= '0;
    end else begin
      o_port_clk_en    <= nxt_port_en;
      o_port_bus_fault <= i_port_access & ~o_port_clk_en;
    end
  end

  // ****************************************
  // System clock source
  // ****************************************

  // Override only matters once deep sleep is being entered or held
  assign ovr_active = int_osc_ovr_ff & (nxt_mode == clk_gate_pkg::MODE_DEEP);

  // Outside deep sleep the run configuration is followed; on wake the saved copy is
  // driven for the first run cycle, which equals what was in use at entry
  always_comb begin
    nxt_sysclk_cfg = i_run_clk_cfg;
    if (ovr_active) begin
      // The saved copy only loads at the entry edge, so take the live divider then
      nxt_sysclk_cfg = '{src: clk_gate_pkg::SRC_INT, div: deep_entry ? i_run_clk_cfg.div : saved_cfg_ff.div};
    end else if (nxt_mode == clk_gate_pkg::MODE_DEEP) begin
      nxt_sysclk_cfg = deep_entry ? i_run_clk_cfg : saved_cfg_ff;
    end else if (mode_ff == clk_gate_pkg::MODE_DEEP) begin
      nxt_sysclk_cfg = saved_cfg_ff;
    end
  end

  // Capture the running source and divider at the onset of deep sleep
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      saved_cfg_ff <= '{src: clk_gate_pkg::SRC_MAIN, div: clk_gate_pkg::DIV_RST};
    end else if (deep_entry) begin
      saved_cfg_ff <= i_run_clk_cfg;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sysclk_cfg      <= '{src: clk_gate_pkg::SRC_MAIN, div: clk_gate_pkg::DIV_RST};
      o_int_osc_pwr_en  <= 1'b0;
      o_main_osc_pwr_en <= 1'b1;
      o_power_mode      <= clk_gate_pkg::MODE_RUN;
    end else begin
      o_sysclk_cfg      <= nxt_sysclk_cfg;
      // Internal osc up when forced or selected; main osc down only when forced
      o_int_osc_pwr_en  <= ovr_active | (nxt_sysclk_cfg.src == clk_gate_pkg::SRC_INT);
      o_main_osc_pwr_en <= ~ovr_active;
      o_power_mode      <= nxt_mode;
    end
  end

  // ****************************************
  // Clock verification and regulator
  // ****************************************

  // Pins come from other domains; two flops before any use
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_meta_ff <= 1'b0;
      fault_sync_ff <= 1'b0;
      fault_prev_ff <= 1'b0;
      ldo_meta_ff   <= 1'b0;
      ldo_sync_ff   <= 1'b0;
      ldo_prev_ff   <= 1'b0;
    end else begin
      fault_meta_ff <= i_clk_verif_fault;
      fault_sync_ff <= fault_meta_ff;
      fault_prev_ff <= fault_sync_ff;
      ldo_meta_ff   <= i_ldo_unregulated;
      ldo_sync_ff   <= ldo_meta_ff;
      ldo_prev_ff   <= ldo_sync_ff;
    end
  end

  // Good-clock force latches; a fault present during clear keeps it set
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_good_clk_force  <= 1'b0;
      o_regulator_reset <= 1'b0;
    end else begin
      o_good_clk_force  <= fault_sync_ff | (o_good_clk_force & ~ver_clr_ff);
      o_regulator_reset <= ldo_allow_ff & ldo_sync_ff;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_events[clk_gate_pkg::IRQ_CLK_FAULT] = fault_sync_ff & ~fault_prev_ff;
  assign irq_events[clk_gate_pkg::IRQ_LDO_LOSS]  = ldo_sync_ff & ~ldo_prev_ff;
  assign irq_events[clk_gate_pkg::IRQ_WAKE]      = (mode_ff != clk_gate_pkg::MODE_RUN) &
                                                   (nxt_mode == clk_gate_pkg::MODE_RUN);

  // New events win over a same-cycle write-one-to-clear
  assign nxt_irq_stat = irq_events |
                        (irq_stat_ff & ~((wr_lane0 & hit_stat) ? req.dat[clk_gate_pkg::IRQ_N-1:0] : '0));

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_stat_ff <= clk_gate_pkg::IRQ_RST;
      o_irq       <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      o_irq       <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

endmodule : port_clock_gating_ctrl

`default_nettype wire

// ### testbench/pcg_checker_assertions.sv
`default_nettype none
// ****
// Port checker
// ****
module pcg_checker (
  // Clock, reset and bus
  input wire logic                      i_clk_sys,
  input wire logic                      i_sys_rst,
  input wire logic                      i_wb_cyc,
  input wire logic                      i_wb_stb,
  input wire logic [31:0]               o_wb_dat,
  input wire logic                      o_wb_ack,
  input wire logic                      o_wb_err,
  // Mode control
  input wire logic                      i_sleep_req,
  input wire logic                      i_deep_sleep_req,
  input wire logic                      i_wake_event,
  input wire clk_gate_pkg::power_mode_e o_power_mode,
  input wire logic                      o_main_osc_pwr_en,
  // Ports, fault and regulator
  input wire logic [4:0]                i_port_access,
  input wire logic [4:0]                o_port_clk_en,
  input wire logic [4:0]                o_port_bus_fault,
  input wire logic                      i_clk_verif_fault,
  input wire logic                      o_good_clk_force,
  input wire logic                      i_ldo_unregulated,
  input wire logic                      o_regulator_reset
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  // Request taken, then exactly one kind of answer
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
  endsequence
  sequence s_ans;
    o_wb_ack ^ o_wb_err;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans) else $error("bus request not answered");
  a_ans_single: assert property ((o_wb_ack || o_wb_err) |=> !(o_wb_ack || o_wb_err)) else $error("answer too long");
  a_err_zero: assert property (o_wb_err |-> o_wb_dat == 32'h0) else $error("error carries data");
  a_fault_pulse: assert property (1 |=> o_port_bus_fault == $past(i_port_access & ~o_port_clk_en))
    else $error("port fault mismatch");
  a_sleep_entry: assert property ((o_power_mode == clk_gate_pkg::MODE_RUN && i_sleep_req && !i_deep_sleep_req)
    |=> o_power_mode == clk_gate_pkg::MODE_SLEEP) else $error("sleep not entered");
  a_deep_entry: assert property ((o_power_mode == clk_gate_pkg::MODE_RUN && i_deep_sleep_req)
    |=> o_power_mode == clk_gate_pkg::MODE_DEEP) else $error("deep sleep not entered");
  a_wake_run: assert property ((o_power_mode != clk_gate_pkg::MODE_RUN && i_wake_event)
    |=> o_power_mode == clk_gate_pkg::MODE_RUN) else $error("wake ignored");
  a_run_main: assert property (o_power_mode == clk_gate_pkg::MODE_RUN |-> o_main_osc_pwr_en)
    else $error("main oscillator off in run");
  a_good_clk: assert property (i_clk_verif_fault [*3] |=> o_good_clk_force) else $error("no good clock");
  a_ldo_quiet: assert property (!i_ldo_unregulated [*4] |-> !o_regulator_reset) else $error("spurious reset");
endmodule : pcg_checker
bind port_clock_gating_ctrl pcg_checker u_chk (.i_clk_sys, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .o_wb_dat,
  .o_wb_ack, .o_wb_err, .i_sleep_req, .i_deep_sleep_req, .i_wake_event, .o_power_mode, .o_main_osc_pwr_en,
  .i_port_access, .o_port_clk_en, .o_port_bus_fault, .i_clk_verif_fault, .o_good_clk_force,
  .i_ldo_unregulated, .o_regulator_reset);
`default_nettype wire

// ### testbench/port_units_model.sv
`default_nettype none
// Gated port units: random access strobes, gated or not
module port_units_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_en,
  output logic      [4:0] o_access
);
  integer seed = 32'h8702;  // Fixed seed, repeatable traffic
  // Units knock whether clocked or not, so faults really occur
  always @(posedge i_clk) begin
    o_access <= (i_rst || !i_en) ? 5'h00 : 5'($random(seed));
  end
endmodule : port_units_model
`default_nettype wire

// ### testbench/peripheral_clock_gating_control_tb.sv
`default_nettype none
module peripheral_clock_gating_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, slp = 0, dsl = 0, wk = 0, auto_sleep_gating_select = 0, cvf = 0, ldo = 0, ue = 0;
  logic [11:0] adr = '0;
  logic [31:0] wd = '0;
  logic [3:0]  sel = 4'hF;
  clk_gate_pkg::sysclk_cfg_s cfg = '0, sv, scf;
  clk_gate_pkg::power_mode_e pm;
  logic [31:0] rdat;
  logic ack, err, gcf, rrs, irq, ios, mos, ovr = 0;
  logic [4:0] pa, en, bf, g[3];
  logic [33:0] e, q[$];  // Notes: {check data, err, data}
  logic [11:0] ofs[3] = '{clk_gate_pkg::OFS_RUN_GATE, clk_gate_pkg::OFS_SLEEP_GATE, clk_gate_pkg::OFS_DEEP_GATE};
  integer err_count = 0, checks_done = 0, tc = 0, seed = 32'h8702;
  port_clock_gating_ctrl u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
    .i_sleep_req(slp), .i_deep_sleep_req(dsl), .i_wake_event(wk), .i_auto_sleep_gating_select(auto_sleep_gating_select),
    .i_run_clk_cfg(cfg), .i_port_access(pa), .o_port_clk_en(en), .o_port_bus_fault(bf), .o_sysclk_cfg(scf),
    .o_int_osc_pwr_en(ios), .o_main_osc_pwr_en(mos), .o_power_mode(pm), .i_clk_verif_fault(cvf),
    .o_good_clk_force(gcf), .i_ldo_unregulated(ldo), .o_regulator_reset(rrs), .o_irq(irq));
  port_units_model u_units (.i_clk(clk), .i_rst(rst), .i_en(ue), .o_access(pa));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Classic cycle held until the answer, note queued for the monitor
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d; q.push_back(x);
    do @(posedge clk); while (!(ack | err));
    cyc <= 0; stb <= 0;
  endtask : wb
  // Enter a mode, check enables (clocks only in deep), then wake and check run clocks
  task automatic mode(input logic [1:0] m, input logic [4:0] x);
    sv = cfg;
    @(posedge clk);
    if (m == 2'h1) slp <= 1; else dsl <= 1;
    @(posedge clk);
    slp <= 0; dsl <= 0;
    @(posedge clk);
    chk(32'(pm), 32'(m));
    chk(32'(en), 32'(x));
    if (m == 2'h2) chk({ios, mos, 27'(scf)}, {ovr | sv.src, !ovr, 27'(ovr ? {1'b1, sv.div} : sv)});
    cfg <= 5'($random(seed)); wk <= 1;
    @(posedge clk);
    wk <= 0;
    @(posedge clk);
    chk({mos, 27'(scf), en}, {1'b1, 27'(m == 2'h2 ? sv : cfg), g[0]});
  endtask : mode
  // Monitor: each answer takes the oldest note
  always @(posedge clk) begin
    tc++;
    if (tc == 3000) begin
      err_count++;
      print_verdict();
    end
    if (ack | err) begin
      e = q.size() ? q.pop_front() : 34'h1_0000_0000;
      chk({31'h0, err}, {31'h0, e[32]});
      if (e[33]) chk(rdat, e[31:0]);
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0; ue <= 1; cfg <= 5'($random(seed));
    @(posedge clk);
    chk({pm, en, gcf, rrs, irq}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      g[i] = 5'($random(seed));
      wb(0, ofs[i], 0, {2'b10, 32'h0});
      wb(1, ofs[i], {27'h0, g[i]}, 34'h0);
      wb(0, ofs[i], 0, {2'b10, 27'h0, g[i]});
    end
    @(posedge clk);
    chk(32'(en), 32'(g[0]));
    wb(0, 12'h200, 0, {2'b11, 32'h0});
    auto_sleep_gating_select <= 1;
    mode(2'h1, g[1]);
    mode(2'h2, g[2]);
    wb(1, clk_gate_pkg::OFS_DS_SRC, 32'h1, 34'h0);
    ovr = 1;
    mode(2'h2, g[2]);
    auto_sleep_gating_select <= 0;
    mode(2'h1, g[0]);
    chk(32'(irq), 0);
    wb(1, clk_gate_pkg::OFS_IRQ_MASK, 32'h4, 34'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 1);
    wb(1, clk_gate_pkg::OFS_IRQ_STAT, 32'h4, 34'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 0);
    cvf <= 1;
    repeat (5) @(posedge clk);
    cvf <= 0;
    repeat (5) @(posedge clk);
    chk(32'(gcf), 1);
    wb(0, clk_gate_pkg::OFS_IRQ_STAT, 0, {2'b10, 32'h1});
    wb(1, clk_gate_pkg::OFS_FAULT_CLR, 32'h1, 34'h0);
    wb(0, clk_gate_pkg::OFS_FAULT_CLR, 0, {2'b10, 32'h1});
    wb(1, clk_gate_pkg::OFS_FAULT_CLR, 32'h0, 34'h0);
    chk(32'(gcf), 0);
    ldo <= 1;
    repeat (5) @(posedge clk);
    chk(32'(rrs), 0);
    wb(1, clk_gate_pkg::OFS_LDO_RST, 32'h1, 34'h0);
    repeat (2) @(posedge clk);
    chk(32'(rrs), 1);
    wb(0, clk_gate_pkg::OFS_IRQ_STAT, 0, {2'b10, 32'h3});
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule : peripheral_clock_gating_control_tb
`default_nettype wire
